// file: shared/psc_pkg.sv
package psc_pkg;

  // register byte addresses
  localparam logic [31:0] UNLOCK_KEY_ADDR = 32'h02AC0004;
  localparam logic [31:0] PERIPHERAL_STATE_CONFIG0_ADDR = 32'h02AC0008;
  localparam logic [31:0] PERIPHERAL_STATUS0_ADDR = 32'h02AC0014;
  localparam logic [31:0] PERIPHERAL_STATUS1_ADDR = 32'h02AC0018;
  localparam logic [31:0] ETHERNET_CONFIG_ADDR = 32'h02AC0020;
  localparam logic [31:0] MEMORY_IF_ENABLE_CONFIG_ADDR = 32'h02AC002C;
  localparam logic [31:0] DEBUG_BUFFER_POWERDOWN_ADDR = 32'h02AC0054;

  // reset values
  localparam logic [31:0] UNLOCK_KEY_RESET = 32'hF0F0F0F0;
  localparam logic [31:0] CONFIG0_RESET = 32'h00000000;
  localparam logic [31:0] CONFIG1_RESET = 32'h00000000;
  localparam logic [31:0] ETHERNET_CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] DEBUG_BUFFER_RESET = 32'h00000000;

  // lock key and open window
  localparam logic [31:0] UNLOCK_KEY_VALUE = 32'h0F0A0B00;
  localparam logic [4:0] UNLOCK_WINDOW_CYCLES = 5'h10;

  // peripheral indices
  localparam int NUM_PERIPH = 11;
  localparam int NUM_CFG0 = 9;
  localparam int P_PCI = 0;
  localparam int P_HOST_PORT = 1;
  localparam int P_SERIAL1 = 2;
  localparam int P_ETHERNET = 8;
  localparam int P_EXT_MEMORY = 9;
  localparam int P_DDR = 10;

  // bit of peripheral_state_config0 for peripheral index 0..8
  localparam int CFG0_BIT [NUM_CFG0] = '{20, 18, 16, 14, 12, 10, 8, 6, 4};
  localparam logic [31:0] CONFIG0_WRITE_MASK = 32'h00155550;

  // memory_if_enable_config fields
  localparam int EXT_MEMORY_ENABLE_BIT = 0;
  localparam int DDR_ENABLE_BIT = 1;

  // boot mode codes that auto-enable a peripheral
  localparam logic [3:0] BOOT_HOST_PORT = 4'h1;
  localparam logic [3:0] BOOT_EXT_MEMORY = 4'h4;
  localparam logic [3:0] BOOT_PCI = 4'h7;

  // peripheral_status0: 2-bit state per peripheral from bit 0
  localparam int STATUS_STATE_WIDTH = 2;
  // peripheral_status1 field positions
  localparam int STAT1_MAC_SEL_LSB = 0;
  localparam int STAT1_EEPROM_BIT = 2;
  localparam int STAT1_PCI_PIN_BIT = 3;
  localparam int STAT1_BOOT_LSB = 4;

  typedef enum logic [1:0] {
    PSC_POWERDOWN,
    PSC_DISABLED,
    PSC_ENABLING,
    PSC_ENABLED
  } psc_state_type;

endpackage : psc_pkg

// file: design/psc_state_control.sv
// Summary of operation
// - latch eeprom autoinit select at reset, request load only when pci pin enabled
// - latch two-bit ethernet interface select at reset
// - pin-disabled peripherals: static powerdown, reset, clock off
// - other peripherals start disabled after reset
// - enabled: clock runs, reset released
// - disabled to enabled passes enable-in-progress state
// - boot peripherals enabled automatically after reset
// - key opens one write within 16 cycles
// - memory-interface enable register written without key
// - only cpu or emulator reach the bank
// - config0 drives peripheral state, resets to zero
// - config0 enable bit: 0 disabled, 1 enabled
// - static powerdown persists until next reset
// - memory and ddr enable bits are sticky
module psc_state_control (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // configuration pins, asynchronous
  input wire logic pci_eeprom_autoinit_select,
  input wire logic [1:0] ethernet_interface_select,
  input wire logic pci_pin_enable,
  input wire logic serial_port1_pin_enable,
  input wire logic ethernet_pin_enable,
  input wire logic ext_memory_pin_enable,
  input wire logic ddr_pin_enable,
  input wire logic [3:0] boot_mode,
  // register port
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_master_ok,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // peripheral controls
  output logic [psc_pkg::NUM_PERIPH-1:0] periph_clock_enable,
  output logic [psc_pkg::NUM_PERIPH-1:0] periph_reset_hold,
  output logic [1:0] ethernet_interface_mode,
  output logic pci_eeprom_load
);
  import psc_pkg::*;

  typedef struct packed {
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic straps_done;
    logic [1:0] mac_sel;
    logic eeprom_sel;
    logic eeprom_load;
    logic pci_pin;
    logic [3:0] boot;
    logic [31:0] unlock_key;
    logic [31:0] config0;
    logic [31:0] config1;
    logic [31:0] ethernet_config;
    logic [31:0] debug_buffer;
    logic [4:0] window;
    psc_state_type [NUM_PERIPH-1:0] st;
    logic [NUM_PERIPH-1:0] clk_en;
    logic [NUM_PERIPH-1:0] rst_hold;
    logic [31:0] rdata;
    logic ack;
  } psc_regs_type;

  psc_regs_type r_q;
  psc_regs_type r_d;

  logic [11:0] pins;
  assign pins = {ethernet_interface_select, boot_mode,
                 ddr_pin_enable, ext_memory_pin_enable, ethernet_pin_enable,
                 serial_port1_pin_enable, pci_pin_enable, pci_eeprom_autoinit_select};

  always_comb begin
    logic acc;
    logic wr;
    logic [NUM_PERIPH-1:0] want;
    logic [31:0] stat0;
    acc = 1'b0;
    wr = 1'b0;
    want = '0;
    stat0 = '0;
    r_d = r_q;
    // pins cross into the clock domain before anyone reads them
    r_d.pin_s1 = pins;
    r_d.pin_s2 = r_q.pin_s1;
    acc = reg_req & reg_master_ok;
    wr = acc & reg_write;
    r_d.ack = reg_req;
    r_d.rdata = '0;
    if (r_q.window != 5'h00) begin
      r_d.window = r_q.window - 5'h01;
    end

    for (int i = 0; i < NUM_CFG0; i++) begin
      want[i] = r_q.config0[CFG0_BIT[i]];
    end
    want[P_EXT_MEMORY] = r_q.config1[EXT_MEMORY_ENABLE_BIT];
    want[P_DDR] = r_q.config1[DDR_ENABLE_BIT];

    if (!r_q.straps_done) begin
      // first cycle after reset release: capture configuration once
      r_d.straps_done = 1'b1;
      r_d.eeprom_sel = r_q.pin_s2[0];
      r_d.eeprom_load = r_q.pin_s2[0] & r_q.pin_s2[1];
      r_d.pci_pin = r_q.pin_s2[1];
      r_d.mac_sel = r_q.pin_s2[11:10];
      r_d.boot = r_q.pin_s2[9:6];
      for (int i = 0; i < NUM_PERIPH; i++) begin
        r_d.st[i] = PSC_DISABLED;
      end
      if (!r_q.pin_s2[1]) begin
        r_d.st[P_PCI] = PSC_POWERDOWN;
      end else begin
        r_d.st[P_HOST_PORT] = PSC_POWERDOWN;
      end
      if (!r_q.pin_s2[2]) begin
        r_d.st[P_SERIAL1] = PSC_POWERDOWN;
      end
      if (!r_q.pin_s2[3]) begin
        r_d.st[P_ETHERNET] = PSC_POWERDOWN;
      end
      if (!r_q.pin_s2[4]) begin
        r_d.st[P_EXT_MEMORY] = PSC_POWERDOWN;
      end
      if (!r_q.pin_s2[5]) begin
        r_d.st[P_DDR] = PSC_POWERDOWN;
      end
      // boot peripherals come up enabled with no software write
      if (r_q.pin_s2[9:6] == BOOT_PCI) begin
        r_d.config0[CFG0_BIT[P_PCI]] = 1'b1;
      end
      if (r_q.pin_s2[9:6] == BOOT_HOST_PORT) begin
        r_d.config0[CFG0_BIT[P_HOST_PORT]] = 1'b1;
      end
      if (r_q.pin_s2[9:6] == BOOT_EXT_MEMORY) begin
        r_d.config1[EXT_MEMORY_ENABLE_BIT] = 1'b1;
      end
    end else begin
      // per-peripheral state walk
      for (int i = 0; i < NUM_PERIPH; i++) begin
        unique case (r_q.st[i])
          PSC_POWERDOWN: r_d.st[i] = PSC_POWERDOWN;
          PSC_DISABLED: begin
            // powerdown is held in the state itself, so live pins are not consulted here
            if (want[i]) begin
              r_d.st[i] = PSC_ENABLING;
            end
          end
          PSC_ENABLING: r_d.st[i] = want[i] ? PSC_ENABLED : PSC_DISABLED;
          PSC_ENABLED: begin
            if (!want[i]) begin
              r_d.st[i] = PSC_DISABLED;
            end
          end
        endcase
      end
    end

    // clock runs from enable-in-progress on, reset lifts only when enabled
    for (int i = 0; i < NUM_PERIPH; i++) begin
      r_d.clk_en[i] = r_d.st[i] == PSC_ENABLING || r_d.st[i] == PSC_ENABLED;
      r_d.rst_hold[i] = r_d.st[i] != PSC_ENABLED;
      stat0[2*i +: STATUS_STATE_WIDTH] = r_q.st[i];
    end

    if (wr) begin
      unique case (reg_addr)
        UNLOCK_KEY_ADDR: begin
          r_d.unlock_key = reg_wdata;
          // any other value closes a window that was open
          r_d.window = reg_wdata == UNLOCK_KEY_VALUE ? UNLOCK_WINDOW_CYCLES : 5'h00;
        end
        PERIPHERAL_STATE_CONFIG0_ADDR: begin
          if (r_q.window != 5'h00) begin
            r_d.config0 = reg_wdata & CONFIG0_WRITE_MASK;
            r_d.window = 5'h00;
          end
        end
        MEMORY_IF_ENABLE_CONFIG_ADDR: begin
          // enables only ever set; a zero never clears them
          r_d.config1[EXT_MEMORY_ENABLE_BIT] = r_q.config1[EXT_MEMORY_ENABLE_BIT]
            | reg_wdata[EXT_MEMORY_ENABLE_BIT];
          r_d.config1[DDR_ENABLE_BIT] = r_q.config1[DDR_ENABLE_BIT] | reg_wdata[DDR_ENABLE_BIT];
        end
        ETHERNET_CONFIG_ADDR: r_d.ethernet_config = reg_wdata;
        DEBUG_BUFFER_POWERDOWN_ADDR: r_d.debug_buffer = reg_wdata;
        default: ;
      endcase
    end else if (acc) begin
      unique case (reg_addr)
        UNLOCK_KEY_ADDR: r_d.rdata = r_q.unlock_key;
        PERIPHERAL_STATE_CONFIG0_ADDR: r_d.rdata = r_q.config0;
        PERIPHERAL_STATUS0_ADDR: r_d.rdata = stat0;
        PERIPHERAL_STATUS1_ADDR: begin
          r_d.rdata[STAT1_MAC_SEL_LSB +: 2] = r_q.mac_sel;
          r_d.rdata[STAT1_EEPROM_BIT] = r_q.eeprom_sel;
          r_d.rdata[STAT1_PCI_PIN_BIT] = r_q.pci_pin;
          r_d.rdata[STAT1_BOOT_LSB +: 4] = r_q.boot;
        end
        ETHERNET_CONFIG_ADDR: r_d.rdata = r_q.ethernet_config;
        MEMORY_IF_ENABLE_CONFIG_ADDR: r_d.rdata = r_q.config1;
        DEBUG_BUFFER_POWERDOWN_ADDR: r_d.rdata = r_q.debug_buffer;
        default: r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_q <= '0;
      r_q.unlock_key <= UNLOCK_KEY_RESET;
      r_q.config0 <= CONFIG0_RESET;
      r_q.config1 <= CONFIG1_RESET;
      r_q.ethernet_config <= ETHERNET_CONFIG_RESET;
      r_q.debug_buffer <= DEBUG_BUFFER_RESET;
      r_q.st <= '{default: PSC_DISABLED};
      r_q.rst_hold <= '1;
      // synchronisers keep running in reset so the straps are valid at the first edge after it
      r_q.pin_s1 <= pins;
      r_q.pin_s2 <= r_q.pin_s1;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign reg_ack = r_q.ack;
  assign periph_clock_enable = r_q.clk_en;
  assign periph_reset_hold = r_q.rst_hold;
  assign ethernet_interface_mode = r_q.mac_sel;
  assign pci_eeprom_load = r_q.eeprom_load;

endmodule : psc_state_control

// file: tb/psc_state_control_props.sv
module psc_state_control_props import psc_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic ethernet_pin_enable,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_master_ok,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [NUM_PERIPH-1:0] periph_clock_enable,
  input wire logic [NUM_PERIPH-1:0] periph_reset_hold,
  input wire logic [1:0] ethernet_interface_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [4:0] since_key_q;
  logic [4:0] since_key_d;
  wire wr = reg_req && ce && reg_write && reg_master_ok;
  // any key write, right or wrong, restarts the count since the window may close on a wrong key
  always_comb begin
    since_key_d = since_key_q;
    if (wr && reg_addr == UNLOCK_KEY_ADDR) since_key_d = 5'h00;
    else if (ce && since_key_q != 5'h1F) since_key_d = since_key_q + 5'h01;
  end
  always_ff @(posedge clk) since_key_q <= srst ? 5'h1F : since_key_d;
  sequence key_wr;
    wr && reg_addr == UNLOCK_KEY_ADDR && reg_wdata == UNLOCK_KEY_VALUE;
  endsequence
  sequence eth_wr;
    wr && reg_addr == PERIPHERAL_STATE_CONFIG0_ADDR && reg_wdata[4];
  endsequence
  AST_ACK: assert property (reg_req && ce |=> reg_ack) else $error("no ack");
  AST_REFUSED: assert property (reg_req && ce && !reg_master_ok |=> reg_rdata == 32'h0)
    else $error("refused data");
  AST_RELEASE: assert property ($fell(srst) |=> &periph_reset_hold && periph_clock_enable == '0)
    else $error("reset state");
  AST_CLK_FIRST: assert property (&(periph_reset_hold | $past(periph_clock_enable)))
    else $error("reset freed early");
  AST_HOLD_OFF: assert property (&(periph_reset_hold | periph_clock_enable))
    else $error("clock off in run");
  AST_KEYED: assert property (key_wr ##1 (eth_wr and ethernet_pin_enable) |->
    ##2 periph_clock_enable[P_ETHERNET] ##1 !periph_reset_hold[P_ETHERNET]) else $error("keyed write lost");
  AST_UNKEYED: assert property (eth_wr and (since_key_q > 5'h0F && !$past(wr) &&
    !periph_clock_enable[P_ETHERNET]) |=> !periph_clock_enable[P_ETHERNET] [*3]) else $error("locked write taken");
  AST_STICKY: assert property (periph_clock_enable[P_EXT_MEMORY] |=> periph_clock_enable[P_EXT_MEMORY])
    else $error("sticky lost");
  AST_MODE: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(ethernet_interface_mode))
    else $error("mode moved");
endmodule : psc_state_control_props

bind psc_state_control psc_state_control_props u_props (.*);

// file: tb/psc_state_control_test.sv
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module psc_state_control_test import psc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] KA = UNLOCK_KEY_ADDR, C0 = PERIPHERAL_STATE_CONFIG0_ADDR;
  localparam logic [31:0] M1 = MEMORY_IF_ENABLE_CONFIG_ADDR, EC = ETHERNET_CONFIG_ADDR;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, pci_eeprom_autoinit_select = 1'b1, pci_pin_enable = 1'b1;
  logic serial_port1_pin_enable = 1'b0, ethernet_pin_enable = 1'b1, ext_memory_pin_enable = 1'b1;
  logic ddr_pin_enable = 1'b0, reg_req = 1'b0, reg_write = 1'b0, reg_master_ok = 1'b1;
  logic [1:0] ethernet_interface_select = 2'h0;
  logic [3:0] boot_mode = BOOT_PCI;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, seed = 32'hB3360A2C, r, e;
  logic [31:0] reg_rdata;
  logic reg_ack, pci_eeprom_load;
  logic [NUM_PERIPH-1:0] periph_clock_enable, periph_reset_hold;
  logic [1:0] ethernet_interface_mode;
  logic [31:0] exp_q[$];
  int n_errors = 0, n_compared = 0, cyc = 0;
  psc_state_control dut (.*);
  always #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // one request per cycle; the caller drops it with idle so accesses may run back to back
  task automatic acc(input logic w, input logic [31:0] a, d, x, input logic ok = 1'b1);
    reg_req = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    reg_master_ok = ok;
    exp_q.push_back(x);
    @(negedge clk);
  endtask : acc
  task automatic idle(input int n);
    reg_req = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  always @(negedge clk) if (reg_ack === 1'b1) begin
    e = exp_q.pop_front();
    `CHK(reg_rdata, e)
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    r = rnd();
    ethernet_interface_select = r[1:0];
    repeat (4) @(negedge clk);
    srst = 1'b0;
    idle(4);
    `CHK(ethernet_interface_mode, ethernet_interface_select)
    `CHK(pci_eeprom_load, 1'b1)
    `CHK(periph_clock_enable, 11'h001)
    `CHK(periph_reset_hold, 11'h7FE)
    acc(0, KA, 0, UNLOCK_KEY_RESET);
    acc(0, C0, 0, 32'h00100000);
    acc(0, 32'h02AC0000, 0, 0);
    acc(0, PERIPHERAL_STATUS1_ADDR, 0, {24'h0, BOOT_PCI, 2'b11, ethernet_interface_select});
    acc(1, C0, 32'h10, 0);
    acc(1, KA, 32'h0F0A0B01, 0);
    acc(1, C0, 32'h10, 0);
    acc(0, C0, 0, 32'h00100000);
    acc(1, KA, UNLOCK_KEY_VALUE, 0);
    acc(1, C0, 32'h00110010, 0);
    acc(1, C0, 32'h0, 0);
    `CHK(periph_clock_enable[P_ETHERNET], 1'b1)
    `CHK(periph_reset_hold[P_ETHERNET], 1'b1)
    idle(1);
    `CHK(periph_reset_hold, 11'h6FE)
    `CHK(periph_clock_enable, 11'h101)
    acc(0, C0, 0, 32'h00110010);
    acc(1, KA, UNLOCK_KEY_VALUE, 0);
    idle(16);
    acc(1, C0, 32'h0, 0);
    acc(0, C0, 0, 32'h00110010);
    acc(1, KA, UNLOCK_KEY_VALUE, 0);
    idle(15);
    acc(1, C0, 32'hFFF0FFEF, 0);
    acc(0, C0, 0, 32'h00105540);
    acc(1, M1, 32'hFFFFFFFF, 0);
    acc(0, M1, 0, 32'h3);
    acc(1, M1, 32'h0, 0);
    acc(0, M1, 0, 32'h3);
    idle(4);
    `CHK(periph_clock_enable, 11'h2F9)
    `CHK(periph_reset_hold, 11'h506)
    acc(0, PERIPHERAL_STATUS0_ADDR, 0, 32'h000DFFC3);
    acc(1, EC, 32'hFFFFFFFF, 0, 1'b0);
    acc(0, EC, 0, 0, 1'b0);
    acc(0, EC, 0, 0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      acc(1, EC, r, 0);
      acc(0, EC, 0, r);
      acc(1, DEBUG_BUFFER_POWERDOWN_ADDR, ~r, 0);
      acc(0, DEBUG_BUFFER_POWERDOWN_ADDR, 0, ~r);
    end
    // let the last ack drop before freezing, or a held ack would be checked twice
    idle(1);
    ce = 1'b0;
    reg_req = 1'b1;
    reg_write = 1'b1;
    reg_addr = EC;
    reg_wdata = 32'h0;
    repeat (2) @(negedge clk);
    ce = 1'b1;
    idle(1);
    acc(0, EC, 0, r);
    // second reset: host port pin function and memory boot
    idle(1);
    srst = 1'b1;
    pci_pin_enable = 1'b0;
    boot_mode = BOOT_EXT_MEMORY;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    idle(4);
    `CHK(pci_eeprom_load, 1'b0)
    `CHK(periph_clock_enable, 11'h200)
    `CHK(periph_reset_hold, 11'h5FF)
    acc(0, C0, 0, 32'h0);
    acc(0, M1, 0, 32'h1);
    idle(3);
    print_verdict();
  end
endmodule : psc_state_control_test
